// File: src/bit_flag_exec_pkg.sv
// package for the bit, flag and load execution unit
// assumes one 10 MHz core clock; no other clock domains
package bit_flag_exec_pkg;

  // ==========================================================
  // operation codes presented on the issue port
  // ==========================================================
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_BR_IRQ_EN    = 5'h01, // branch_on_irq_enabled
    OP_BR_IRQ_DIS   = 5'h02, // branch_on_irq_disabled
    OP_IO_BIT_SET   = 5'h03, // io_bit_set
    OP_IO_BIT_CLEAR = 5'h04, // io_bit_clear
    OP_SHIFT_LEFT   = 5'h05, // logic_shift_left
    OP_SHIFT_RIGHT  = 5'h06, // logic_shift_right
    OP_ROT_LEFT     = 5'h07, // rotate_left_carry
    OP_ROT_RIGHT    = 5'h08, // rotate_right_carry
    OP_ARITH_RIGHT  = 5'h09, // arith_shift_right
    OP_NIBBLE_SWAP  = 5'h0a,
    OP_FLAG_SET     = 5'h0b, // generic_flag_set, flag chosen by i_bit
    OP_FLAG_CLEAR   = 5'h0c, // generic_flag_clear, flag chosen by i_bit
    OP_IRQ_ON       = 5'h0d, // interrupts_on
    OP_IRQ_OFF      = 5'h0e, // interrupts_off
    OP_BIT_STORE_T  = 5'h0f, // bit_store_to_t
    OP_BIT_LOAD_T   = 5'h10, // bit_load_from_t
    OP_REG_COPY     = 5'h11, // register_copy
    OP_PAIR_COPY    = 5'h12, // register_pair_copy
    OP_IMM_LOAD     = 5'h13, // immediate_load
    OP_IND_LOAD     = 5'h14, // indirect_load through x or y
    OP_DISP_LOAD    = 5'h15  // displacement_load through y
  } op_t;

  // pointer update mode of the indirect load
  typedef enum logic [1:0] {
    PTR_PLAIN    = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_PRE_DEC  = 2'b10
  } ptr_mode_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_IO     = 2'b01,
    ST_LOAD   = 2'b10,
    ST_BRANCH = 2'b11
  } state_t;

  // ==========================================================
  // status_register flag positions
  // ==========================================================
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // ==========================================================
  // pointer register indices (low byte; high byte is index+1)
  // ==========================================================
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;

  // ==========================================================
  // host port addresses (0x00..0x1f hit the register file)
  // ==========================================================
  localparam logic [5:0] HOST_STATUS = 6'h20;
  localparam logic [5:0] HOST_PC_LO  = 6'h21;
  localparam logic [5:0] HOST_PC_HI  = 6'h22;
  localparam logic [5:0] HOST_STATE  = 6'h23;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [7:0]  REG_RST    = 8'h00;

endpackage

// File: src/bit_flag_and_load_exec.sv
// execution unit: interrupt-flag branches, i/o bit ops, shifts, flags,
// t-bit transfer, moves and indirect loads through x and y
// assumes issue waits for o_busy low and one-cycle far-side reads
`timescale 1ns/10ps

module bit_flag_and_load_exec
  import bit_flag_exec_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // instruction issue
  input wire logic i_op_valid,
  input wire op_t i_op,
  input wire logic [4:0] i_rd,
  input wire logic [4:0] i_rr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_imm,
  input wire logic [6:0] i_offset,
  input wire logic i_ptr_is_y,
  input wire ptr_mode_t i_ptr_mode,
  input wire logic [5:0] i_disp,
  input wire logic [4:0] i_io_port,
  // instruction status
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_pc,
  output logic [7:0] o_status,
  // i/o space
  output logic [4:0] o_io_addr,
  output logic o_io_rd,
  output logic o_io_wr,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  // data memory
  output logic [15:0] o_dmem_addr,
  output logic o_dmem_rd,
  input wire logic [7:0] i_dmem_rdata,
  // host register port
  input wire logic [5:0] i_host_addr,
  input wire logic [7:0] i_host_wdata,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  output logic [7:0] o_host_rdata
);

  // ==========================================================
  // storage
  // ==========================================================
  logic [7:0] regs_r [32]; // general working registers
  logic [7:0] status_r; // status_register
  logic [15:0] pc_r; // program counter
  state_t state_r; // sequencer state
  logic [4:0] dest_r; // destination held across a load
  logic [2:0] bit_r; // bit held across an i/o access
  logic set_r; // i/o access sets (1) or clears (0)
  // ==========================================================
  // helpers
  // ==========================================================
  // flags after a shift: v is n xor c, as for every shift of this core
  function automatic logic [7:0] shift_flags(input logic [7:0] s,
                                             input logic [7:0] res,
                                             input logic c);
    logic [7:0] f;
    f = s;
    f[FLAG_C] = c;
    f[FLAG_Z] = (res == 8'h00);
    f[FLAG_N] = res[7];
    f[FLAG_V] = res[7] ^ c;
    return f;
  endfunction
  // read a 16-bit pointer pair from the register file
  function automatic logic [15:0] pair(input logic [4:0] lo);
    return {regs_r[lo + 5'h01], regs_r[lo]};
  endfunction
  // ==========================================================
  // decode of the issued instruction
  // ==========================================================
  logic take; // instruction accepted this cycle
  logic [7:0] src; // rr operand
  logic [7:0] dst; // rd operand
  logic [4:0] ptr_lo; // pointer pair selected
  logic [15:0] ptr; // pointer value before update
  logic [15:0] ptr_dec; // pointer minus one
  logic [15:0] ptr_inc; // pointer plus one
  logic [15:0] k_ext; // sign-extended branch offset
  logic [7:0] sh_res; // shift result
  logic sh_c; // shift carry out
  logic is_shift; // one of the five shifts
  logic br_take; // branch condition holds
  assign take = i_op_valid && (state_r == ST_IDLE);
  assign src = regs_r[i_rr];
  assign dst = regs_r[i_rd];
  assign ptr_lo = i_ptr_is_y ? PTR_Y_LO : PTR_X_LO;
  // a process, so that register writes reach the pointer at once
  always_comb ptr = pair(ptr_lo);
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_inc = ptr + 16'h0001;
  assign k_ext = {{9{i_offset[6]}}, i_offset};
  assign is_shift = (i_op == OP_SHIFT_LEFT) || (i_op == OP_SHIFT_RIGHT) ||
                    (i_op == OP_ROT_LEFT) || (i_op == OP_ROT_RIGHT) ||
                    (i_op == OP_ARITH_RIGHT);
  assign br_take =
    ((i_op == OP_BR_IRQ_EN) && status_r[FLAG_I]) ||
    ((i_op == OP_BR_IRQ_DIS) && !status_r[FLAG_I]);
  // shifter shared by the five shift forms
  always_comb
  begin
    sh_res = dst;
    sh_c = status_r[FLAG_C];
    unique case (i_op)
      OP_SHIFT_LEFT:
      begin
        sh_res = {dst[6:0], 1'b0};
        sh_c = dst[7];
      end
      OP_SHIFT_RIGHT:
      begin
        sh_res = {1'b0, dst[7:1]};
        sh_c = dst[0];
      end
      OP_ROT_LEFT:
      begin
        sh_res = {dst[6:0], status_r[FLAG_C]};
        sh_c = dst[7];
      end
      OP_ROT_RIGHT:
      begin
        sh_res = {status_r[FLAG_C], dst[7:1]};
        sh_c = dst[0];
      end
      OP_ARITH_RIGHT:
      begin
        sh_res = {dst[7], dst[7:1]};
        sh_c = dst[0];
      end
      default: ; // other operations keep the defaults above
    endcase
  end

  // ==========================================================
  // sequencer: one-cycle ops stay idle, two-cycle ops take a state
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (take)
          begin
            if ((i_op == OP_IO_BIT_SET) || (i_op == OP_IO_BIT_CLEAR))
              state_r <= ST_IO;
            else if ((i_op == OP_IND_LOAD) || (i_op == OP_DISP_LOAD))
              state_r <= ST_LOAD;
            else if (br_take)
              state_r <= ST_BRANCH; // taken branch costs a second cycle
          end
        end
        // every second cycle returns to idle
        ST_IO, ST_LOAD, ST_BRANCH:
          state_r <= ST_IDLE;
      endcase
    end
  end
  // busy and done: done pulses on the cycle after the last one
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_busy <= take && (br_take || (i_op == OP_IO_BIT_SET) ||
                (i_op == OP_IO_BIT_CLEAR) || (i_op == OP_IND_LOAD) ||
                (i_op == OP_DISP_LOAD));
      o_done <= (state_r != ST_IDLE) || (take && !(br_take ||
                (i_op == OP_IO_BIT_SET) || (i_op == OP_IO_BIT_CLEAR) ||
                (i_op == OP_IND_LOAD) || (i_op == OP_DISP_LOAD)));
    end
  end

  // ==========================================================
  // program counter: one word per instruction
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pc_r <= PC_RST;
    else if (take && br_take)
      pc_r <= pc_r + k_ext + 16'h0001;
    else if (take)
      pc_r <= pc_r + 16'h0001; // untaken branch falls through
    else if (i_host_wr && (i_host_addr == HOST_PC_LO))
      pc_r <= {pc_r[15:8], i_host_wdata};
    else if (i_host_wr && (i_host_addr == HOST_PC_HI))
      pc_r <= {i_host_wdata, pc_r[7:0]};
  end

  // ==========================================================
  // status register; branches, loads, moves leave it alone
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      status_r <= STATUS_RST;
    else if (take && is_shift)
      status_r <= shift_flags(status_r, sh_res, sh_c);
    else if (take && (i_op == OP_FLAG_SET))
      status_r[i_bit] <= 1'b1;
    else if (take && (i_op == OP_FLAG_CLEAR))
      status_r[i_bit] <= 1'b0;
    else if (take && (i_op == OP_IRQ_ON))
      status_r[FLAG_I] <= 1'b1;
    else if (take && (i_op == OP_IRQ_OFF))
      status_r[FLAG_I] <= 1'b0;
    else if (take && (i_op == OP_BIT_STORE_T))
      status_r[FLAG_T] <= src[i_bit];
    else if (i_host_wr && (i_host_addr == HOST_STATUS))
      status_r <= i_host_wdata; // host write loses to an instruction that writes flags
  end

  // ==========================================================
  // register file: one port for ops, one for load data, host last
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < 32; i++)
        regs_r[i] <= REG_RST;
    end
    else
    begin
      if (take)
      begin
        unique case (i_op)
          OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT,
          OP_ARITH_RIGHT:
            regs_r[i_rd] <= sh_res;
          OP_NIBBLE_SWAP:
            regs_r[i_rd] <= {dst[3:0], dst[7:4]};
          OP_BIT_LOAD_T:
            regs_r[i_rd][i_bit] <= status_r[FLAG_T];
          OP_REG_COPY:
            regs_r[i_rd] <= src;
          OP_PAIR_COPY:
          begin
            // pair indices are forced even
            regs_r[{i_rd[4:1], 1'b0}] <= regs_r[{i_rr[4:1], 1'b0}];
            regs_r[{i_rd[4:1], 1'b1}] <= regs_r[{i_rr[4:1], 1'b1}];
          end
          OP_IMM_LOAD:
            regs_r[i_rd] <= i_imm;
          OP_IND_LOAD:
          begin
            // pointer update lands in the first cycle
            if (i_ptr_mode == PTR_POST_INC)
            begin
              regs_r[ptr_lo] <= ptr_inc[7:0];
              regs_r[ptr_lo + 5'h01] <= ptr_inc[15:8];
            end
            else if (i_ptr_mode == PTR_PRE_DEC)
            begin
              regs_r[ptr_lo] <= ptr_dec[7:0];
              regs_r[ptr_lo + 5'h01] <= ptr_dec[15:8];
            end
          end
          default: ; // nothing written to the register file
        endcase
      end
      if (state_r == ST_LOAD)
        regs_r[dest_r] <= i_dmem_rdata;
      if (i_host_wr && !i_host_addr[5] && (state_r == ST_IDLE) && !take)
        regs_r[i_host_addr[4:0]] <= i_host_wdata;
    end
  end

  // ==========================================================
  // data memory read: address in cycle one, data in cycle two
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_dmem_rd <= 1'b0;
      o_dmem_addr <= 16'h0000;
      dest_r <= 5'h00;
    end
    else
    begin
      o_dmem_rd <= take && ((i_op == OP_IND_LOAD) ||
                            (i_op == OP_DISP_LOAD));
      if (take && (i_op == OP_IND_LOAD))
      begin
        dest_r <= i_rd;
        // pre-decrement reads the new address
        o_dmem_addr <= (i_ptr_mode == PTR_PRE_DEC) ? ptr_dec : ptr;
      end
      else if (take && (i_op == OP_DISP_LOAD))
      begin
        dest_r <= i_rd;
        o_dmem_addr <= pair(PTR_Y_LO) + {10'h000, i_disp};
      end
    end
  end

  // ==========================================================
  // i/o read-modify-write; other bits come back as read
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_io_rd <= 1'b0;
      o_io_wr <= 1'b0;
      o_io_addr <= 5'h00;
      o_io_wdata <= 8'h00;
      bit_r <= 3'h0;
      set_r <= 1'b0;
    end
    else
    begin
      o_io_rd <= take && ((i_op == OP_IO_BIT_SET) ||
                          (i_op == OP_IO_BIT_CLEAR));
      o_io_wr <= (state_r == ST_IO);
      if (take && ((i_op == OP_IO_BIT_SET) || (i_op == OP_IO_BIT_CLEAR)))
      begin
        o_io_addr <= i_io_port;
        bit_r <= i_bit;
        set_r <= (i_op == OP_IO_BIT_SET);
      end
      if (state_r == ST_IO)
      begin
        o_io_wdata <= i_io_rdata;
        o_io_wdata[bit_r] <= set_r;
      end
    end
  end

  // ==========================================================
  // host read data, one cycle after the strobe
  // ==========================================================
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_host_rdata <= 8'h00;
    else if (i_host_rd)
    begin
      if (!i_host_addr[5])
        o_host_rdata <= regs_r[i_host_addr[4:0]];
      else if (i_host_addr == HOST_STATUS)
        o_host_rdata <= status_r;
      else if (i_host_addr == HOST_PC_LO)
        o_host_rdata <= pc_r[7:0];
      else if (i_host_addr == HOST_PC_HI)
        o_host_rdata <= pc_r[15:8];
      else if (i_host_addr == HOST_STATE)
        o_host_rdata <= {6'h00, state_r};
      else
        o_host_rdata <= 8'h00; // unmapped reads as zero
    end
    else
      o_host_rdata <= 8'h00;
  end
  // mirrors of internal state
  assign o_pc = pc_r;
  assign o_status = status_r;

endmodule // bit_flag_and_load_exec

// File: dv/bit_flag_exec_sva.sv
// checker for the bit, flag and load execution unit
// sees only the top ports; bound into every instance at the foot
`timescale 1ns/10ps

module bit_flag_exec_sva
  import bit_flag_exec_pkg::*;
(
  // clock, reset and issue
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_op_valid,
  input wire op_t i_op,
  input wire logic [2:0] i_bit,
  input wire logic [6:0] i_offset,
  // instruction status
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [15:0] o_pc,
  input wire logic [7:0] o_status,
  // far side
  input wire logic o_io_rd,
  input wire logic o_io_wr,
  input wire logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  input wire logic o_dmem_rd
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic tk; // instruction taken at this edge
  logic [15:0] ofs; // sign-extended branch offset
  assign tk = i_op_valid && !o_busy;
  assign ofs = {{9{i_offset[6]}}, i_offset};

  // ==========================================================
  // branches: taken ones jump and take a second cycle
  // ==========================================================
  property p_branch_on_irq_enabled_tk;
    tk && i_op == OP_BR_IRQ_EN && o_status[FLAG_I] |=> o_busy &&
      o_pc == $past(o_pc) + $past(ofs) + 16'h0001 ##1 o_done;
  endproperty
  a_branch_on_irq_enabled_tk: assert property (p_branch_on_irq_enabled_tk)
    else $error("enabled branch taken wrongly");
  property p_branch_on_irq_enabled_nt;
    tk && i_op == OP_BR_IRQ_EN && !o_status[FLAG_I] |=>
      o_done && !o_busy && o_pc == $past(o_pc) + 16'h0001;
  endproperty
  a_branch_on_irq_enabled_nt: assert property (p_branch_on_irq_enabled_nt)
    else $error("enabled branch not in sequence");
  property p_branch_on_irq_disabled_tk;
    tk && i_op == OP_BR_IRQ_DIS && !o_status[FLAG_I] |=> o_busy &&
      o_pc == $past(o_pc) + $past(ofs) + 16'h0001 ##1 o_done;
  endproperty
  a_branch_on_irq_disabled_tk: assert property (p_branch_on_irq_disabled_tk)
    else $error("disabled branch taken wrongly");

  // ==========================================================
  // i/o bit set and clear: read, then write back one bit changed
  // ==========================================================
  property p_io_set;
    tk && i_op == OP_IO_BIT_SET |=> o_io_rd ##1 o_io_wr && o_done &&
      o_io_wdata == ($past(i_io_rdata) | (8'h01 << $past(i_bit, 2)));
  endproperty
  a_io_set: assert property (p_io_set)
    else $error("i/o bit set wrong");
  property p_io_clr;
    tk && i_op == OP_IO_BIT_CLEAR |=> o_io_rd ##1 o_io_wr && o_done &&
      o_io_wdata == ($past(i_io_rdata) & ~(8'h01 << $past(i_bit, 2)));
  endproperty
  a_io_clr: assert property (p_io_clr)
    else $error("i/o bit clear wrong");
  property p_io_flags;
    tk && (i_op == OP_IO_BIT_SET || i_op == OP_IO_BIT_CLEAR) |=>
      ##1 o_status == $past(o_status, 2);
  endproperty
  a_io_flags: assert property (p_io_flags)
    else $error("i/o bit op touched flags");

  // ==========================================================
  // one-cycle flag and shift work
  // ==========================================================
  property p_shift;
    tk && i_op >= OP_SHIFT_LEFT && i_op <= OP_ARITH_RIGHT |=> o_done &&
      !o_busy && (o_status & 8'hf0) == ($past(o_status) & 8'hf0);
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift not one cycle or wrong flags");
  property p_fset;
    tk && i_op == OP_FLAG_SET |=>
      o_status == ($past(o_status) | (8'h01 << $past(i_bit)));
  endproperty
  a_fset: assert property (p_fset)
    else $error("flag set wrong");
  property p_fclr;
    tk && i_op == OP_FLAG_CLEAR |=>
      o_status == ($past(o_status) & ~(8'h01 << $past(i_bit)));
  endproperty
  a_fclr: assert property (p_fclr)
    else $error("flag clear wrong");
  property p_irq_on;
    tk && i_op == OP_IRQ_ON |=> o_status == ($past(o_status) | 8'h80);
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("interrupts on wrong");

  // ==========================================================
  // loads: memory read in the second cycle, flags kept
  // ==========================================================
  property p_load;
    tk && (i_op == OP_IND_LOAD || i_op == OP_DISP_LOAD) |=> o_dmem_rd &&
      o_busy ##1 o_done && !o_dmem_rd && o_status == $past(o_status, 2);
  endproperty
  a_load: assert property (p_load)
    else $error("load timing or flags wrong");

  c_br: cover property (tk && i_op == OP_BR_IRQ_EN && o_status[FLAG_I]);
  c_io: cover property (o_io_rd ##1 o_io_wr);
  c_ld: cover property (o_dmem_rd ##1 o_done);
endmodule // bit_flag_exec_sva

bind bit_flag_and_load_exec bit_flag_exec_sva u_chk (.*);

// File: dv/exec_mem_model.sv
// far-side model: i/o space and data memory of the core
// answers in the strobe cycle and holds one cycle; stale data inverts
`timescale 1ns/10ps

module exec_mem_model
(
  // clock
  input wire logic i_clk,
  // i/o space
  input wire logic [4:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // data memory, contents are a function of the address
  input wire logic [15:0] i_dmem_addr,
  input wire logic i_dmem_rd,
  output logic [7:0] o_dmem_rdata
);
  logic [7:0] io_mem [32]; // i/o registers
  logic [7:0] io_q = 8'h00; // last i/o byte, then its inverse
  logic [7:0] dm_q = 8'h00; // last memory byte, then its inverse
  logic [7:0] dm_byte; // memory content at the address

  // known fill so read-modify-write results can be predicted
  initial
  begin
    for (int i = 0; i < 32; i++)
      io_mem[i] = 8'(i) ^ 8'ha5;
  end

  assign dm_byte = i_dmem_addr[7:0] ^ i_dmem_addr[15:8] ^ 8'h3c;
  assign o_io_rdata = i_io_rd ? io_mem[i_io_addr] : io_q;
  assign o_dmem_rdata = i_dmem_rd ? dm_byte : dm_q;

  // write-back of the modified i/o byte
  always @(posedge i_clk)
  begin
    if (i_io_wr)
      io_mem[i_io_addr] <= i_io_wdata;
    io_q <= i_io_rd ? io_mem[i_io_addr] : ~io_q;
    dm_q <= i_dmem_rd ? dm_byte : ~dm_q;
  end
endmodule // exec_mem_model

// File: dv/test_bit_flag_and_load_exec.sv
// self-checking bench for the bit, flag and load execution unit
// far side is exec_mem_model; registers seen through the host port
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module test_bit_flag_and_load_exec
  import bit_flag_exec_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_op_valid = 1'b0;
  op_t i_op = OP_NOP;
  logic [4:0] i_rd = 5'h00, i_rr = 5'h00, i_io_port = 5'h00;
  logic [2:0] i_bit = 3'h0;
  logic [7:0] i_imm = 8'h00, i_host_wdata = 8'h00;
  logic [6:0] i_offset = 7'h00;
  logic i_ptr_is_y = 1'b0, i_host_wr = 1'b0, i_host_rd = 1'b0;
  ptr_mode_t i_ptr_mode = PTR_PLAIN;
  logic [5:0] i_disp = 6'h00, i_host_addr = 6'h00;
  logic o_busy, o_done, o_io_rd, o_io_wr, o_dmem_rd;
  logic [15:0] o_pc, o_dmem_addr;
  logic [7:0] o_status, o_io_wdata, i_io_rdata, i_dmem_rdata;
  logic [7:0] o_host_rdata;
  logic [4:0] o_io_addr;
  int failures = 0, checks = 0;
  localparam op_t SH [5] = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT,
    OP_ROT_RIGHT, OP_ARITH_RIGHT};

  initial forever #50 i_clk = ~i_clk;

  bit_flag_and_load_exec i_bit_flag_and_load_exec (.*);
  exec_mem_model i_exec_mem_model (.i_clk, .i_io_addr(o_io_addr),
    .i_io_rd(o_io_rd), .i_io_wr(o_io_wr), .i_io_wdata(o_io_wdata),
    .o_io_rdata(i_io_rdata), .i_dmem_addr(o_dmem_addr),
    .i_dmem_rd(o_dmem_rd), .o_dmem_rdata(i_dmem_rdata));

  // ==========================================================
  // port tasks: one-cycle strobes, results read mid-cycle
  // ==========================================================
  task automatic issue(input op_t op, input logic [4:0] rd, rr,
    input logic [2:0] b, input logic [7:0] k, output int lat);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_rd <= rd;
    i_rr <= rr;
    i_bit <= b;
    i_imm <= k;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    @(negedge i_clk);
    lat = 1;
    while (o_done !== 1'b1 && lat < 4)
    begin
      @(negedge i_clk);
      lat++;
    end
  endtask

  task automatic hwr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_host_wr <= 1'b1;
    i_host_addr <= a;
    i_host_wdata <= d;
    @(posedge i_clk);
    i_host_wr <= 1'b0;
  endtask

  task automatic reg_is(input logic [5:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_host_rd <= 1'b1;
    i_host_addr <= a;
    @(posedge i_clk);
    i_host_rd <= 1'b0;
    @(negedge i_clk);
    `CHK(o_host_rdata, e)
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_flags;
    int lat;
    logic [7:0] e;
    hwr(HOST_STATUS, 8'h00);
    e = 8'h00;
    for (int b = 0; b < 16; b++)
    begin
      // first pass sets every flag, second clears every flag
      issue(b < 8 ? OP_FLAG_SET : OP_FLAG_CLEAR, 0, 0, 3'(b), 0, lat);
      e = b < 8 ? e | (8'h01 << b) : e & ~(8'h01 << (b - 8));
      `CHK(o_status, e)
      `CHK(lat, 1)
    end
    issue(OP_IRQ_ON, 0, 0, 0, 0, lat);
    `CHK(o_status, 8'h80)
    issue(OP_IRQ_OFF, 0, 0, 0, 0, lat);
    `CHK(o_status, 8'h00)
  endtask

  task automatic t_shift;
    int lat;
    logic [7:0] v, r, st;
    logic c, ci;
    for (int j = 0; j < 10; j++)
    begin
      v = j < 5 ? 8'h96 : 8'h01;
      ci = j < 5;
      st = {7'h18, ci};
      hwr(6'h10, v);
      hwr(HOST_STATUS, st);
      issue(SH[j % 5], 5'h10, 0, 0, 0, lat);
      case (SH[j % 5])
        OP_SHIFT_LEFT: r = {v[6:0], 1'b0};
        OP_SHIFT_RIGHT: r = {1'b0, v[7:1]};
        OP_ROT_LEFT: r = {v[6:0], ci};
        OP_ROT_RIGHT: r = {ci, v[7:1]};
        default: r = {v[7], v[7:1]};
      endcase
      c = (j % 5 == 0 || j % 5 == 2) ? v[7] : v[0];
      `CHK(o_status, {st[7:4], r[7] ^ c, r[7], r == 8'h00, c})
      `CHK(lat, 1)
      reg_is(6'h10, r);
    end
  endtask

  task automatic t_branch;
    int lat;
    logic tk;
    for (int j = 0; j < 4; j++)
    begin
      issue(j[0] ? OP_IRQ_ON : OP_IRQ_OFF, 0, 0, 0, 0, lat);
      hwr(HOST_PC_LO, 8'h40);
      hwr(HOST_PC_HI, 8'h00);
      i_offset <= 7'h7e;
      issue(j[1] ? OP_BR_IRQ_DIS : OP_BR_IRQ_EN, 0, 0, 0, 0, lat);
      tk = j[1] != j[0];
      `CHK(o_pc, tk ? 16'h003f : 16'h0041)
      `CHK(lat, tk ? 2 : 1)
    end
  endtask

  task automatic t_io;
    int lat;
    i_io_port <= 5'h0b;
    hwr(HOST_STATUS, 8'h5a);
    for (int j = 0; j < 2; j++)
    begin
      issue(j ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 0, 0, j ? 3'h7 : 3'h4,
        0, lat);
      `CHK(o_io_wr, 1'b1)
      `CHK(o_io_addr, 5'h0b)
      `CHK(o_io_wdata, j ? 8'h3e : 8'hbe)
      `CHK(lat, 2)
      `CHK(o_status, 8'h5a)
    end
  endtask

  task automatic t_xfer;
    int lat;
    hwr(6'h05, 8'h24);
    hwr(6'h06, 8'h80);
    hwr(6'h04, 8'h11);
    hwr(HOST_STATUS, 8'h00);
    issue(OP_BIT_STORE_T, 0, 5'h05, 3'h2, 0, lat);
    `CHK(o_status, 8'h40)
    issue(OP_BIT_LOAD_T, 5'h06, 0, 3'h0, 0, lat);
    reg_is(6'h06, 8'h81);
    issue(OP_REG_COPY, 5'h07, 5'h05, 0, 0, lat);
    reg_is(6'h07, 8'h24);
    issue(OP_NIBBLE_SWAP, 5'h05, 0, 0, 0, lat);
    reg_is(6'h05, 8'h42);
    issue(OP_PAIR_COPY, 5'h09, 5'h05, 0, 0, lat);
    reg_is(6'h08, 8'h11);
    reg_is(6'h09, 8'h42);
    issue(OP_IMM_LOAD, 5'h03, 0, 0, 8'hc3, lat);
    reg_is(6'h03, 8'hc3);
    `CHK(o_status, 8'h40)
    issue(OP_BIT_STORE_T, 0, 5'h05, 3'h0, 0, lat);
    `CHK(o_status, 8'h00)
    reg_is(6'h30, 8'h00);
    reg_is(HOST_STATE, 8'h00);
  endtask

  task automatic t_load;
    int lat;
    hwr(6'h1a, 8'h20);
    hwr(6'h1b, 8'h01);
    hwr(6'h1c, 8'h00);
    hwr(6'h1d, 8'h02);
    hwr(HOST_STATUS, 8'h21);
    issue(OP_IND_LOAD, 5'h01, 0, 0, 0, lat);
    `CHK(lat, 2)
    reg_is(6'h01, 8'h1d);
    i_ptr_mode <= PTR_POST_INC;
    issue(OP_IND_LOAD, 5'h02, 0, 0, 0, lat);
    reg_is(6'h02, 8'h1d);
    reg_is(6'h1a, 8'h21);
    i_ptr_is_y <= 1'b1;
    i_ptr_mode <= PTR_PRE_DEC;
    issue(OP_IND_LOAD, 5'h04, 0, 0, 0, lat);
    `CHK(lat, 2)
    reg_is(6'h04, 8'hc2);
    reg_is(6'h1d, 8'h01);
    i_ptr_mode <= PTR_PLAIN;
    i_disp <= 6'h01;
    issue(OP_DISP_LOAD, 5'h0b, 0, 0, 0, lat);
    `CHK(lat, 2)
    reg_is(6'h0b, 8'h3e);
    reg_is(6'h1c, 8'hff);
    `CHK(o_status, 8'h21)
  endtask

  // ==========================================================
  // run control
  // ==========================================================
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reset for 20 cycles, then each scenario in turn
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_flags;
    t_shift;
    t_branch;
    t_io;
    t_xfer;
    t_load;
    print_verdict;
  end

  // the scenarios need well under 2000 cycles; a hang ends here
  initial
  begin
    repeat (6000) @(posedge i_clk);
    failures++;
    print_verdict;
  end
endmodule // test_bit_flag_and_load_exec
